/* File: design/uart_efc_cfg.svh */
// How it works
// [R1] auto clear-to-send on: clear-to-send at 1 stops new data characters; flow characters still go out
// [R2] auto clear-to-send on: transmit restarts when clear-to-send returns to 0
// [R3] auto request-to-send on: level flag rises when fill reaches trigger
// [R4] auto request-to-send on: pin goes 1 at fill above trigger
// [R5] auto request-to-send on: pin back to 0 below trigger minus one
// [R6] auto request-to-send off: pin is the inverse of modem control bit 1
// [R7] special detect on: each received character compared with second stop char
// [R8] matched character still stored; special flag set in interrupt status
// [R9] all eight bits of flow characters are compared with the received character
// [R10] host clears flow select bits before enabling special detect
// [R11] enhanced bit high: protected enhanced bits are writable
// [R12] enhanced bit cleared: protected bits latched against legacy writes
// [R13] low four control bits select transmit and receive flow control
// [R14] enhanced feature register resets to all zero
// [R15] upper select bits: none, first pair, second pair, both in sequence
// [R16] lower select bits: none, first pair, second pair, both pairs
// [R17] far party never sends flow characters as plain data
// [R18] enhanced bit low: protected bit writes ignored, values kept
// [R19] special flag stays set until host reads interrupt status
`ifndef UART_EFC_CFG_SVH
`define UART_EFC_CFG_SVH

`define A_DATA      4'h0
`define A_IER       4'h1
`define A_ISR       4'h2
`define A_FCR       4'h3
`define A_MCR       4'h4
`define A_EFR       4'h5
`define A_FIRST_RESUME_CHAR      4'h6
`define A_SECOND_RESUME_CHAR      4'h7
`define A_FIRST_STOP_CHAR     4'h8
`define A_SECOND_STOP_CHAR     4'h9
`define A_TRIG      4'hA
`define A_STAT      4'hB

`define EFR_AUTO_CTS  7
`define EFR_AUTO_RTS  6
`define EFR_SPECIAL   5
`define EFR_ENHANCED  4
`define MCR_RTS       1
`define ISR_SPECIAL   4
`define ISR_PROT      5

`define FIFO_DEPTH    4
`define REG_RESET     8'h00
`define TRIG_RESET    3'h2

`endif

/* File: design/uart_efc_pkg.sv */
package uart_efc_pkg;
    typedef enum logic [1:0] {
        FL_IDLE = 2'b00,
        FL_ONE  = 2'b01,
        FL_TWO  = 2'b10
    } flow_state_e;
    typedef logic [3:0] reg_addr_t;
    typedef logic [7:0] byte_t;
endpackage

/* File: design/uart_efc.sv */
`include "uart_efc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module efc_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset,
    // filling side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [W-1:0]             in_data,
    // draining side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [W-1:0]                  out_data,
    output logic [$clog2(D):0]            level
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    wire           push = in_valid & in_ready;
    wire           pop  = out_valid & out_ready;

    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign level     = cnt_r;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            if (pop) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module uart_efc
    import uart_efc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // register port
    input  wire reg_addr_t  addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    // received characters
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_char,
    output logic            rx_ready,
    // characters to transmitter
    output logic            tx_valid,
    output logic [7:0]      tx_char,
    input  wire logic       tx_ready,
    // handshake pins and level flag
    input  wire logic       cts_pin,
    output logic            rts_pin,
    output logic            rx_level_irq
);
    byte_t       efr_r, ier_r, isr_r, fcr_r, mcr_r;
    byte_t       first_resume_char_r, second_resume_char_r, first_stop_char_r, second_stop_char_r;
    logic [2:0]  trig_r;
    byte_t       rdata_r, hold_r, txc_r;
    logic        hold_full_r, txv_r, rts_r, lvl_r;
    logic        rstop_r, lstop_r, kind_r;
    flow_state_e fl_r, fl_nxt;
    byte_t       fifo_q;
    logic        fifo_ov, fifo_in_rdy;
    logic [2:0]  cnt;

    // decode
    wire we_data  = wr & (addr == `A_DATA);
    wire we_ier   = wr & (addr == `A_IER);
    wire we_isr   = wr & (addr == `A_ISR);
    wire we_fcr   = wr & (addr == `A_FCR);
    wire we_mcr   = wr & (addr == `A_MCR);
    wire we_efr   = wr & (addr == `A_EFR);
    wire rd_data  = rd & (addr == `A_DATA);
    wire rd_isr   = rd & (addr == `A_ISR);
    wire enh      = efr_r[`EFR_ENHANCED];
    wire rx_take  = rx_valid & fifo_in_rdy;

    // protected bit merge
    wire [7:0] ier_w = enh ? wdata : {ier_r[7:4], wdata[3:0]}; // R11 R12 R18
    wire [7:0] fcr_w = enh ? wdata : {wdata[7:6], fcr_r[5:4], wdata[3:0]}; // R11 R12 R18
    wire [7:0] mcr_w = enh ? wdata : {mcr_r[7:5], wdata[4:0]}; // R11 R12 R18
    wire       isr5_w = enh ? wdata[`ISR_PROT] : isr_r[`ISR_PROT]; // R11 R18

    // receive comparison
    wire [1:0] rx_sel = efr_r[1:0]; // R13 R16
    wire [1:0] tx_sel = efr_r[3:2]; // R13 R15
    wire both_seq     = (efr_r[3:0] == 4'hF); // R16
    wire m_on1  = (rx_char == first_resume_char_r); // R9
    wire m_on2  = (rx_char == second_resume_char_r); // R9
    wire m_off1 = (rx_char == first_stop_char_r); // R9
    wire m_off2 = (rx_char == second_stop_char_r); // R9
    logic prev_off1_r, prev_on1_r;
    wire stop_hit = rx_take & (both_seq ? (prev_off1_r & m_off2)
                  : ((rx_sel[1] & m_off1) | (rx_sel[0] & m_off2))); // R16
    wire res_hit  = rx_take & (both_seq ? (prev_on1_r & m_on2)
                  : ((rx_sel[1] & m_on1) | (rx_sel[0] & m_on2))); // R16
    wire special  = rx_take & efr_r[`EFR_SPECIAL] & m_off2; // R7 R8

    // level thresholds
    wire lv_hi = (cnt > trig_r); // R4
    wire lv_lo = ({1'b0, cnt} + 4'h1) < {1'b0, trig_r}; // R5
    wire lv_at = (cnt >= trig_r); // R3

    // transmit slot
    wire slot_free = ~txv_r | tx_ready;
    wire cts_block = efr_r[`EFR_AUTO_CTS] & cts_pin; // R1 R2
    wire send_fl   = slot_free & (fl_r != FL_IDLE);
    wire send_dat  = slot_free & ~send_fl & hold_full_r & ~cts_block
                   & ~rstop_r; // R1 R2
    wire [7:0] fl_char = (fl_r == FL_ONE) ? (kind_r ? first_stop_char_r : first_resume_char_r)
                                          : (kind_r ? second_stop_char_r : second_resume_char_r); // R15
    wire go_stop = (tx_sel != 2'b00) & ~lstop_r & lv_hi & (fl_r == FL_IDLE);
    wire go_res  = (tx_sel != 2'b00) & lstop_r & lv_lo & (fl_r == FL_IDLE);

    // flow character sequencer
    always_comb begin
        fl_nxt = fl_r;
        case (fl_r)
            FL_IDLE: begin
                if (go_stop | go_res) begin
                    fl_nxt = (tx_sel == 2'b01) ? FL_TWO : FL_ONE; // R15
                end
            end
            FL_ONE: begin
                if (send_fl) begin
                    fl_nxt = (tx_sel == 2'b11) ? FL_TWO : FL_IDLE; // R15
                end
            end
            FL_TWO: begin
                if (send_fl) fl_nxt = FL_IDLE;
            end
            default: fl_nxt = FL_IDLE;
        endcase
    end

    // read mux
    wire [7:0] stat = {cts_pin, rstop_r, lstop_r, hold_full_r, rts_r, cnt};
    wire [7:0] rd_nxt =
        (addr == `A_DATA)  ? (fifo_ov ? fifo_q : `REG_RESET) :
        (addr == `A_IER)   ? ier_r :
        (addr == `A_ISR)   ? isr_r :
        (addr == `A_FCR)   ? fcr_r :
        (addr == `A_MCR)   ? mcr_r :
        (addr == `A_EFR)   ? efr_r :
        (addr == `A_FIRST_RESUME_CHAR)  ? first_resume_char_r :
        (addr == `A_SECOND_RESUME_CHAR)  ? second_resume_char_r :
        (addr == `A_FIRST_STOP_CHAR) ? first_stop_char_r :
        (addr == `A_SECOND_STOP_CHAR) ? second_stop_char_r :
        (addr == `A_TRIG)  ? {5'h00, trig_r} :
        (addr == `A_STAT)  ? stat : `REG_RESET;

    // receive buffer
    efc_fifo #(.W(8), .D(`FIFO_DEPTH)) rx_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_valid  (rx_valid),
        .in_ready  (fifo_in_rdy),
        .in_data   (rx_char),
        .out_valid (fifo_ov),
        .out_ready (rd_data),
        .out_data  (fifo_q),
        .level     (cnt)
    ); // R8

    assign rx_ready     = fifo_in_rdy;
    assign rdata        = rdata_r;
    assign tx_valid     = txv_r;
    assign tx_char      = txc_r;
    assign rts_pin      = rts_r;
    assign rx_level_irq = lvl_r;

    // host registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            efr_r   <= `REG_RESET; // R14
            ier_r   <= `REG_RESET;
            fcr_r   <= `REG_RESET;
            mcr_r   <= `REG_RESET;
            first_resume_char_r  <= `REG_RESET;
            second_resume_char_r  <= `REG_RESET;
            first_stop_char_r <= `REG_RESET;
            second_stop_char_r <= `REG_RESET;
            trig_r  <= `TRIG_RESET;
            rdata_r <= `REG_RESET;
        end else begin
            if (we_efr) efr_r <= wdata;
            if (we_ier) ier_r <= ier_w;
            if (we_fcr) fcr_r <= fcr_w;
            if (we_mcr) mcr_r <= mcr_w;
            if (wr && addr == `A_FIRST_RESUME_CHAR) first_resume_char_r <= wdata;
            if (wr && addr == `A_SECOND_RESUME_CHAR) second_resume_char_r <= wdata;
            if (wr && addr == `A_FIRST_STOP_CHAR) first_stop_char_r <= wdata;
            if (wr && addr == `A_SECOND_STOP_CHAR) second_stop_char_r <= wdata;
            if (wr && addr == `A_TRIG) trig_r <= wdata[2:0];
            rdata_r <= rd ? rd_nxt : `REG_RESET;
        end
    end

    // interrupt status, set wins over read clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            isr_r <= `REG_RESET;
        end else begin
            if (we_isr) isr_r[`ISR_PROT] <= isr5_w; // R12 R18
            if (special) begin
                isr_r[`ISR_SPECIAL] <= 1'b1; // R8 R19
            end else if (rd_isr) begin
                isr_r[`ISR_SPECIAL] <= 1'b0; // R19
            end
        end
    end

    // receive side flow state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prev_off1_r <= 1'b0;
            prev_on1_r  <= 1'b0;
            rstop_r     <= 1'b0;
        end else begin
            if (rx_take) prev_off1_r <= m_off1;
            if (rx_take) prev_on1_r <= m_on1;
            if (rx_sel == 2'b00) rstop_r <= 1'b0; // R16
            else if (stop_hit) rstop_r <= 1'b1;
            else if (res_hit) rstop_r <= 1'b0;
        end
    end

    // handshake pins and level flag
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rts_r <= 1'b1;
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= efr_r[`EFR_AUTO_RTS] & lv_at; // R3
            if (!efr_r[`EFR_AUTO_RTS]) rts_r <= ~mcr_r[`MCR_RTS]; // R6
            else if (lv_hi) rts_r <= 1'b1; // R4
            else if (lv_lo) rts_r <= 1'b0; // R5
        end
    end

    // transmit path
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hold_r      <= `REG_RESET;
            hold_full_r <= 1'b0;
            txv_r       <= 1'b0;
            txc_r       <= `REG_RESET;
            fl_r        <= FL_IDLE;
            kind_r      <= 1'b0;
            lstop_r     <= 1'b0;
        end else begin
            fl_r <= fl_nxt;
            if (go_stop | go_res) kind_r <= go_stop;
            if (go_stop) lstop_r <= 1'b1;
            else if (go_res || tx_sel == 2'b00) lstop_r <= 1'b0;
            if (we_data && !hold_full_r) begin
                hold_r      <= wdata;
                hold_full_r <= 1'b1;
            end else if (send_dat) begin
                hold_full_r <= 1'b0;
            end
            if (send_fl) begin
                txv_r <= 1'b1;
                txc_r <= fl_char; // R15
            end else if (send_dat) begin
                txv_r <= 1'b1;
                txc_r <= hold_r;
            end else if (tx_ready) begin
                txv_r <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: tb/uart_efc_assertions.sv */
`include "uart_efc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_efc_chk
    import uart_efc_pkg::*;
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       reset,
    // register port
    input wire reg_addr_t  addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // streams and pins
    input wire logic       rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic       rx_ready,
    input wire logic       tx_valid,
    input wire logic       cts_pin,
    input wire logic       rts_pin,
    input wire logic       rx_level_irq
);
    logic [7:0] efr_r;
    logic [7:0] xo_r;
    logic [2:0] cnt_r;
    logic [2:0] trig_r;
    logic       mcr1_r;
    logic       sp_r;
    wire push = rx_valid && rx_ready;
    wire pop  = rd && addr == `A_DATA && cnt_r != 3'h0;
    wire hit  = push && efr_r[5] && rx_char == xo_r;
    // mirror of control state seen at the ports
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            efr_r  <= 8'h00;
            xo_r   <= 8'h00;
            cnt_r  <= 3'h0;
            trig_r <= 3'h2;
            mcr1_r <= 1'b0;
            sp_r   <= 1'b0;
        end else begin
            if (wr && addr == `A_EFR) efr_r <= wdata;
            if (wr && addr == `A_SECOND_STOP_CHAR) xo_r <= wdata;
            if (wr && addr == `A_TRIG) trig_r <= wdata[2:0];
            if (wr && addr == `A_MCR) mcr1_r <= wdata[1];
            cnt_r <= cnt_r + {2'b0, push} - {2'b0, pop};
            sp_r  <= hit || (sp_r && !(rd && addr == `A_ISR));
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_cts_halt;
        efr_r[7] && efr_r[3:2] == 2'b00 && cts_pin && !tx_valid
            |=> !tx_valid;
    endproperty
    a_cts_halt: assert property (p_cts_halt)
        else $error("transmit began while stopped");
    property p_rts_manual;
        !wr && !efr_r[6] |=> rts_pin == !$past(mcr1_r);
    endproperty
    a_rts_manual: assert property (p_rts_manual)
        else $error("rts not following control bit");
    property p_rts_high;
        efr_r[6] && cnt_r > trig_r |=> rts_pin;
    endproperty
    a_rts_high: assert property (p_rts_high)
        else $error("rts low above trigger");
    property p_rts_low;
        efr_r[6] && {1'b0, cnt_r} + 4'h1 < {1'b0, trig_r} |=> !rts_pin;
    endproperty
    a_rts_low: assert property (p_rts_low)
        else $error("rts high below lower level");
    property p_level;
        efr_r[6] && cnt_r >= trig_r |=> rx_level_irq;
    endproperty
    a_level: assert property (p_level)
        else $error("level flag missing");
    property p_full;
        cnt_r == 3'h4 |-> !rx_ready;
    endproperty
    a_full: assert property (p_full)
        else $error("ready while buffer full");
    property p_special;
        rd && addr == `A_ISR |=> rdata[4] == $past(sp_r);
    endproperty
    a_special: assert property (p_special)
        else $error("special flag wrong");
    property p_efr_read;
        rd && addr == `A_EFR |=> rdata == $past(efr_r);
    endproperty
    a_efr_read: assert property (p_efr_read)
        else $error("control register readback wrong");
endmodule
bind uart_efc uart_efc_chk chk_u (.mclk, .reset, .addr, .wdata, .wr,
    .rd, .rdata, .rx_valid, .rx_char, .rx_ready, .tx_valid, .cts_pin,
    .rts_pin, .rx_level_irq);
`default_nettype wire

/* File: tb/modem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module modem_model
    import uart_efc_pkg::*;
(
    // clock
    input  wire logic mclk,
    // characters toward the block
    output logic      rx_valid,
    output byte_t     rx_char,
    input  wire logic rx_ready,
    // characters from the block
    input  wire logic tx_valid,
    output logic      tx_ready,
    // handshake
    output logic      cts_pin
);
    logic cts_req = 1'b0;
    logic slow    = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_char  = 8'h00;
        tx_ready = 1'b1;
        cts_pin  = 1'b0;
    end
    // slow mode stalls every other cycle
    always @(posedge mclk) begin
        tx_ready <= slow ? !tx_ready : 1'b1;
        cts_pin  <= cts_req;
    end
    // sends any character, flow characters included, and waits for rx_ready
    task automatic send_char(input byte_t c);
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_char  <= c;
        @(posedge mclk iff rx_ready);
        rx_valid <= 1'b0;
        rx_char  <= ~c;
    endtask
endmodule
`default_nettype wire

/* File: tb/uart_efc_tb.sv */
`include "uart_efc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin check_count++; if ((ex) !== (sn)) begin \
    miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, ex, sn); \
    end end
module uart_efc_tb
    import uart_efc_pkg::*;
    ;
    logic       mclk  = 1'b0;
    logic       reset = 1'b1;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic       rd_q  = 1'b0;
    reg_addr_t  addr  = 4'h0;
    byte_t      wdata = 8'h00;
    logic [7:0] rdata;
    logic       rx_valid, rx_ready, tx_valid, tx_ready;
    logic       cts_pin, rts_pin, rx_level_irq;
    byte_t      rx_char, tx_char, c;
    byte_t      q[$];
    byte_t      exp_tx[$];
    logic [15:0] exp_rd[$];
    int         miscompares = 0;
    int         check_count = 0;
    int         seed = 85;
    int         i;
    always #4 mclk = ~mclk;
    uart_efc dut_u (.mclk, .reset, .addr, .wdata, .wr, .rd, .rdata,
        .rx_valid, .rx_char, .rx_ready, .tx_valid, .tx_char, .tx_ready,
        .cts_pin, .rts_pin, .rx_level_irq);
    modem_model mdm_u (.mclk, .rx_valid, .rx_char, .rx_ready, .tx_valid,
        .tx_ready, .cts_pin);
    task automatic wr_reg(input reg_addr_t a, input byte_t d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input reg_addr_t a, input byte_t e, input byte_t m);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        exp_rd.push_back({e, m});
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    task automatic wait_tx;
        for (i = 0; i < 200 && exp_tx.size() > 0; i++)
            @(posedge mclk);
        `CHK("tx drained", 0, exp_tx.size())
    endtask
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // compares results against the oldest note
    always @(posedge mclk) begin
        logic [15:0] note;
        rd_q <= rd;
        if (rd_q) begin
            note = exp_rd.pop_front();
            `CHK("rdata", note[15:8] & note[7:0], rdata & note[7:0])
        end
        if (tx_valid && tx_ready)
            `CHK("tx_char", exp_tx.pop_front(), tx_char)
    end
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rd_reg(`A_EFR, 8'h00, 8'hff);
        for (int k = 0; k < 16; k++) begin
            wr_reg(`A_EFR, 8'(k));
            rd_reg(`A_EFR, 8'(k), 8'hff);
        end
        wr_reg(`A_EFR, 8'h00);
        wr_reg(`A_IER, 8'hff);
        rd_reg(`A_IER, 8'h0f, 8'hff);
        wr_reg(`A_EFR, 8'h10);
        wr_reg(`A_IER, 8'ha5);
        rd_reg(`A_IER, 8'ha5, 8'hff);
        wr_reg(`A_FCR, 8'h30);
        wr_reg(`A_MCR, 8'he0);
        wr_reg(`A_ISR, 8'h20);
        rd_reg(`A_FCR, 8'h30, 8'hff);
        rd_reg(`A_MCR, 8'he0, 8'hff);
        rd_reg(`A_ISR, 8'h20, 8'h20);
        wr_reg(`A_EFR, 8'h00);
        wr_reg(`A_IER, 8'h03);
        rd_reg(`A_IER, 8'ha3, 8'hff);
        wr_reg(`A_FCR, 8'h00);
        wr_reg(`A_MCR, 8'h00);
        wr_reg(`A_ISR, 8'h00);
        rd_reg(`A_FCR, 8'h30, 8'hff);
        rd_reg(`A_MCR, 8'he0, 8'hff);
        rd_reg(`A_ISR, 8'h20, 8'h20);
        $display("test registers done");
        mdm_u.slow    = 1'b1;
        mdm_u.cts_req = 1'b1;
        wr_reg(`A_EFR, 8'h80);
        for (int k = 0; k < 3; k++) begin
            c = byte_t'($random(seed));
            exp_tx.push_back(c);
            wr_reg(`A_DATA, c);
            repeat (6) @(posedge mclk);
            `CHK("tx held", 1'b0, tx_valid)
            mdm_u.cts_req = 1'b0;
            wait_tx();
            mdm_u.cts_req = 1'b1;
        end
        mdm_u.cts_req = 1'b0;
        $display("test cts done");
        wr_reg(`A_EFR, 8'h40);
        for (int k = 0; k < 4; k++) begin
            q.push_back(byte_t'($random(seed)));
            mdm_u.send_char(q[k]);
        end
        fork
            mdm_u.send_char(8'h5a);
        join_none
        repeat (3) @(posedge mclk);
        `CHK("rts high", 1'b1, rts_pin)
        `CHK("rx full", 1'b0, rx_ready)
        `CHK("level", 1'b1, rx_level_irq)
        q.push_back(8'h5a);
        for (int k = 0; k < 5; k++)
            rd_reg(`A_DATA, q[k], 8'hff);
        rd_reg(`A_DATA, 8'h00, 8'hff);
        repeat (3) @(posedge mclk);
        `CHK("rts low", 1'b0, rts_pin)
        wr_reg(`A_EFR, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr_reg(`A_MCR, 8'(2 - 2 * k));
            repeat (2) @(posedge mclk);
            `CHK("rts manual", 1'(k), rts_pin)
        end
        $display("test rts done");
        c = byte_t'($random(seed));
        wr_reg(`A_SECOND_STOP_CHAR, c);
        wr_reg(`A_EFR, 8'h20);
        mdm_u.send_char(c ^ 8'h01);
        rd_reg(`A_ISR, 8'h00, 8'h10);
        mdm_u.send_char(c);
        rd_reg(`A_ISR, 8'h10, 8'h10);
        rd_reg(`A_ISR, 8'h00, 8'h10);
        rd_reg(`A_DATA, c ^ 8'h01, 8'hff);
        rd_reg(`A_DATA, c, 8'hff);
        repeat (3) @(posedge mclk);
        $display("test special done");
        mdm_u.slow = 1'b0;
        wr_reg(`A_FIRST_STOP_CHAR, 8'h13);
        wr_reg(`A_FIRST_RESUME_CHAR, 8'h11);
        wr_reg(`A_EFR, 8'h08);
        exp_tx.push_back(8'h13);
        for (int k = 0; k < 3; k++)
            mdm_u.send_char(8'(8'h40 + k));
        wait_tx();
        exp_tx.push_back(8'h11);
        for (int k = 0; k < 3; k++)
            rd_reg(`A_DATA, 8'(8'h40 + k), 8'hff);
        wait_tx();
        wr_reg(`A_EFR, 8'h02);
        mdm_u.send_char(8'h13);
        exp_tx.push_back(8'h5a);
        wr_reg(`A_DATA, 8'h5a);
        repeat (6) @(posedge mclk);
        `CHK("tx stopped", 1'b0, tx_valid)
        mdm_u.send_char(8'h11);
        wait_tx();
        rd_reg(`A_DATA, 8'h13, 8'hff);
        rd_reg(`A_DATA, 8'h11, 8'hff);
        repeat (3) @(posedge mclk);
        $display("test soft flow done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
